//--- pkg/tapp_pkg.sv
// shared types and constants for the test access port pin block
package tapp_pkg;

  // pins sampled from the probe, packed in one carrier
  typedef struct packed {
    logic tck;     // test clock
    logic tms;     // mode select
    logic tdi;     // serial data in
    logic trstN;   // test reset, active low
  } tapp_pins_t;

  localparam int          PIN_COUNT   = 4;
  // idle levels: clock pulled low, the rest pulled high
  localparam tapp_pins_t  PINS_RESET  = '{tck: 1'b0, tms: 1'b1,
                                          tdi: 1'b1, trstN: 1'b1};

  typedef enum logic [3:0] {
    TLR        = 4'h0,
    RUN_IDLE   = 4'h1,
    SEL_DR     = 4'h2,
    CAPTURE_DR = 4'h3,
    SHIFT_DR   = 4'h4,
    EXIT1_DR   = 4'h5,
    PAUSE_DR   = 4'h6,
    EXIT2_DR   = 4'h7,
    UPDATE_DR  = 4'h8,
    SEL_IR     = 4'h9,
    CAPTURE_IR = 4'ha,
    SHIFT_IR   = 4'hb,
    EXIT1_IR   = 4'hc,
    PAUSE_IR   = 4'hd,
    EXIT2_IR   = 4'he,
    UPDATE_IR  = 4'hf
  } tapp_state_t;

  localparam int           IR_WIDTH      = 4;
  localparam int           DR_WIDTH      = 32;
  localparam logic [3:0]   IR_IDCODE     = 4'h2;
  localparam logic [3:0]   IR_BYPASS     = 4'hf;
  localparam logic [3:0]   IR_CAPTURE    = 4'h1;
  // arbitrary identification value, names no part
  localparam logic [31:0]  ID_VALUE      = 32'h0000_1001;
  localparam logic [2:0]   PULL_ON       = 3'h7;
  localparam logic [2:0]   PULL_OFF      = 3'h0;

endpackage

//--- core/tapp_pin_sync.sv
// three-flop synchronisers with agreement filter and edge pulses
module tapp_pin_sync
  import tapp_pkg::*;
(
  input  wire logic       core_clk,  // system clock
  input  wire logic       reset,     // synchronous, active high
  input  wire tapp_pins_t pinsIn,    // raw pins from the probe
  output tapp_pins_t      pinsLvl,   // filtered levels
  output tapp_pins_t      pinsRise,  // one-cycle rising pulses
  output tapp_pins_t      pinsFall   // one-cycle falling pulses
);

  logic [PIN_COUNT-1:0] s1Q;
  logic [PIN_COUNT-1:0] s2Q;
  logic [PIN_COUNT-1:0] s3Q;
  logic [PIN_COUNT-1:0] lvlQ;
  logic [PIN_COUNT-1:0] riseQ;
  logic [PIN_COUNT-1:0] fallQ;

  // the test reset path never sees the system reset, so a test reset
  // held together with a system reset still clears the controller
  localparam tapp_pins_t SYS_RESET_MASK = '{tck: 1'h1, tms: 1'h1,
                                            tdi: 1'h1, trstN: 1'h0};

  // s1 feeds only s2; a change counts once s2 and s3 agree
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (reset && SYS_RESET_MASK[i]) begin
          s1Q[i]   <= PINS_RESET[i];
          s2Q[i]   <= PINS_RESET[i];
          s3Q[i]   <= PINS_RESET[i];
          lvlQ[i]  <= PINS_RESET[i];
          riseQ[i] <= 1'b0;
          fallQ[i] <= 1'b0;
        end else begin
          s1Q[i]   <= pinsIn[i];
          s2Q[i]   <= s1Q[i];
          s3Q[i]   <= s2Q[i];
          riseQ[i] <= (s2Q[i] == s3Q[i]) && s3Q[i] && !lvlQ[i];
          fallQ[i] <= (s2Q[i] == s3Q[i]) && !s3Q[i] && lvlQ[i];
          if (s2Q[i] == s3Q[i]) begin
            lvlQ[i] <= s3Q[i];
          end
        end
      end
    end
  endgenerate

  assign pinsLvl  = lvlQ;
  assign pinsRise = riseQ;
  assign pinsFall = fallQ;

endmodule // tapp_pin_sync

//--- core/tapp_port.sv
// test access port controller, sampled from the probe pins
// Contract
// - state advances on mode select at clock rise
// - data input captured on test clock rise
// - data output driven only in shift states
// - data output changes on falling clock edges
// - low test reset forces controller reset
// - system reset leaves controller state intact
// - pull-disable bit turns test pull-ups off
module tapp_port
  import tapp_pkg::*;
(
  input  wire logic       core_clk,     // 40 MHz system clock
  input  wire logic       reset,        // system reset, active high
  input  wire tapp_pins_t pins,         // probe pins, asynchronous
  input  wire logic       pullDisable,  // test-port pull-disable bit
  output logic            tdo,          // serial data out
  output logic            tdoEn,        // data out driver enable
  output logic [2:0]      pullUpEn,     // pull-ups on tms, tdi, trst
  output tapp_state_t     tapState,     // controller state
  output logic [3:0]      instr         // active instruction
);

  tapp_pins_t           lvl;
  tapp_pins_t           rise;
  tapp_pins_t           fall;
  tapp_state_t          stateQ;
  tapp_state_t          stateD;
  logic [3:0]           irShQ;
  logic [3:0]           irQ;
  logic [DR_WIDTH-1:0]  drShQ;
  logic                 tdoQ;
  logic                 tdoEnQ;
  logic [2:0]           pullQ;
  logic                 tckRise;
  logic                 tckFall;
  logic                 bypass;

  tapp_pin_sync u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinsIn   (pins),
    .pinsLvl  (lvl),
    .pinsRise (rise),
    .pinsFall (fall)
  );

  assign tckRise = rise.tck;
  assign tckFall = fall.tck;
  assign bypass  = (irQ != IR_IDCODE);

  ////////////////////////////////////////////////////////////////////////
  // controller sequence
  function automatic tapp_state_t nextState(tapp_state_t s, logic m);
    unique case (s)
      TLR:        nextState = m ? TLR       : RUN_IDLE;
      RUN_IDLE:   nextState = m ? SEL_DR    : RUN_IDLE;
      SEL_DR:     nextState = m ? SEL_IR    : CAPTURE_DR;
      CAPTURE_DR: nextState = m ? EXIT1_DR  : SHIFT_DR;
      SHIFT_DR:   nextState = m ? EXIT1_DR  : SHIFT_DR;
      EXIT1_DR:   nextState = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:   nextState = m ? EXIT2_DR  : PAUSE_DR;
      EXIT2_DR:   nextState = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:  nextState = m ? SEL_DR    : RUN_IDLE;
      SEL_IR:     nextState = m ? TLR       : CAPTURE_IR;
      CAPTURE_IR: nextState = m ? EXIT1_IR  : SHIFT_IR;
      SHIFT_IR:   nextState = m ? EXIT1_IR  : SHIFT_IR;
      EXIT1_IR:   nextState = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:   nextState = m ? EXIT2_IR  : PAUSE_IR;
      EXIT2_IR:   nextState = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:  nextState = m ? SEL_DR    : RUN_IDLE;
    endcase
  endfunction

  assign stateD = nextState(stateQ, lvl.tms);

  // only the test reset clears the controller, so a system reset
  // during a debug session keeps the probe's place
  always_ff @(posedge core_clk) begin
    if (!lvl.trstN) begin
      stateQ <= TLR;
    end else if (tckRise) begin
      stateQ <= stateD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction path
  always_ff @(posedge core_clk) begin
    if (!lvl.trstN || (tckRise && stateQ == TLR)) begin
      irQ   <= IR_IDCODE;
      irShQ <= IR_CAPTURE;
    end else if (tckRise) begin
      unique case (stateQ)
        CAPTURE_IR: irShQ <= IR_CAPTURE;
        SHIFT_IR:   irShQ <= {lvl.tdi, irShQ[3:1]};
        UPDATE_IR:  irQ   <= irShQ;
        default:    irShQ <= irShQ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data path: one bit long in bypass, full width for the id value
  always_ff @(posedge core_clk) begin
    if (!lvl.trstN) begin
      drShQ <= '0;
    end else if (tckRise) begin
      if (stateQ == CAPTURE_DR) begin
        drShQ <= bypass ? '0 : ID_VALUE;
      end else if (stateQ == SHIFT_DR) begin
        if (bypass) begin
          drShQ[0] <= lvl.tdi;
        end else begin
          drShQ <= {lvl.tdi, drShQ[DR_WIDTH-1:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output, updated on the test clock fall, three system clocks ahead of the probe sample
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tdoQ <= 1'b0;
    end else if (tckFall) begin
      tdoQ <= (stateQ == SHIFT_IR) ? irShQ[0] : drShQ[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || !lvl.trstN) begin
      tdoEnQ <= 1'b0;
    end else if (tckFall) begin
      tdoEnQ <= (stateQ == SHIFT_IR) || (stateQ == SHIFT_DR);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pullQ <= PULL_ON;
    end else begin
      pullQ <= pullDisable ? PULL_OFF : PULL_ON;
    end
  end

  assign tdo      = tdoQ;
  assign tdoEn    = tdoEnQ;
  assign pullUpEn = pullQ;
  assign tapState = stateQ;
  assign instr    = irQ;

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_STATE_ON_RISE: assert property (
    @(posedge core_clk) disable iff (!lvl.trstN)
    $changed(stateQ) |-> $past(tckRise))
    else $error("controller moved without a test clock rise");

  AST_TDI_CAPTURE: assert property (
    @(posedge core_clk) disable iff (!lvl.trstN)
    (tckRise && stateQ == SHIFT_DR && bypass) |=>
      drShQ[0] == $past(lvl.tdi))
    else $error("bypass bit did not take data input");

  AST_TDO_EN_SHIFT: assert property (
    @(posedge core_clk) disable iff (reset || !lvl.trstN)
    tckFall |=> tdoEnQ ==
      ($past(stateQ) == SHIFT_IR || $past(stateQ) == SHIFT_DR))
    else $error("driver enable does not follow shift state");

  AST_TDO_ON_FALL: assert property (
    @(posedge core_clk) disable iff (reset)
    $changed(tdoQ) |-> $past(tckFall))
    else $error("data output changed off a falling edge");

  AST_TRST_RESETS: assert property (
    @(posedge core_clk)
    (!lvl.trstN) ##1 (!lvl.trstN) |-> stateQ == TLR && irQ == IR_IDCODE)
    else $error("test reset did not reset controller");

  AST_SYSRESET_KEEPS: assert property (
    @(posedge core_clk)
    (reset && lvl.trstN && !tckRise) |=> $stable(stateQ))
    else $error("system reset disturbed controller state");

  AST_PULL_OFF: assert property (
    @(posedge core_clk)
    (!reset && pullDisable) |=> pullQ == PULL_OFF ##1 1'b1)
    else $error("pull-ups not disabled");

  AST_RESET_TDO_OFF: assert property (
    @(posedge core_clk)
    reset |=> !tdoEnQ)
    else $error("data output driven during reset");

  AST_TLR_TO_IDLE: assert property (
    @(posedge core_clk) disable iff (!lvl.trstN)
    (tckRise && stateQ == TLR && !lvl.tms) |=> stateQ == RUN_IDLE)
    else $error("reset state did not move to idle");

  AST_SHIFT_LOOP: assert property (
    @(posedge core_clk) disable iff (!lvl.trstN)
    (tckRise && stateQ == EXIT2_IR && !lvl.tms) |=> stateQ == SHIFT_IR)
    else $error("exit2 did not return to shift");

  AST_IR_UPDATE: assert property (
    @(posedge core_clk) disable iff (!lvl.trstN)
    (tckRise && stateQ == UPDATE_IR) |=> irQ == $past(irShQ))
    else $error("instruction not taken from shift register");

  AST_PULL_ON: assert property (
    @(posedge core_clk)
    (!reset && !pullDisable) |=> pullQ == PULL_ON)
    else $error("pull-ups off without the disable bit");

  AST_TDO_IR_SOURCE: assert property (
    @(posedge core_clk) disable iff (reset)
    (tckFall && stateQ == SHIFT_IR) |=> tdoQ == $past(irShQ[0]))
    else $error("data output not taken from instruction shift");

endmodule // tapp_port

//--- bench/tapp_probe.sv
// probe model: drives the test pins and samples the resolved data line
module tapp_probe
  import tapp_pkg::*;
(
  input  wire logic       core_clk,  // system clock
  input  wire logic       tdoWire,   // resolved data output line
  output tapp_pins_t      pins       // pins driven by the probe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pins = PINS_RESET;
  end

  task automatic setTrst(input logic v);
    pins.trstN <= v;
  endtask

  // data set while the clock is low, held well past the rise
  task automatic rise(input logic m, input logic d);
    pins.tms <= m;
    pins.tdi <= d;
    repeat (4) @(posedge core_clk);
    pins.tck <= 1'b1;
  endtask

  // sampled late in the high phase: synchroniser lag moves the
  // data change to just after the rising pin edge
  task automatic fall(output logic o);
    repeat (4) @(posedge core_clk);
    o = tdoWire;
    pins.tck <= 1'b0;
  endtask
endmodule // tapp_probe

//--- bench/tb_tapp_port.sv
// testbench for the test access port pin block
module tb_tapp_port
  import tapp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;     // system clock
  logic        reset;        // system reset
  logic        pullDisable;  // pull-disable bit
  tapp_pins_t  pins;         // probe pins
  logic        tdo;          // data out
  logic        tdoEn;        // data out enable
  logic [2:0]  pullUpEn;     // pull-up enables
  tapp_state_t tapState;     // controller state
  logic [3:0]  instr;        // instruction
  logic        tdoWire;      // resolved data line
  int          n_mismatch = 0;
  int          n_compared = 0;
  localparam logic [23:0] WALK_TMS = 24'hfd4f52;
  tapp_state_t walkSt [24] = '{TLR, RUN_IDLE, SEL_DR, CAPTURE_DR,
    SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, SHIFT_DR, EXIT1_DR,
    UPDATE_DR, SEL_DR, SEL_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
    PAUSE_IR, EXIT2_IR, SHIFT_IR, EXIT1_IR, UPDATE_IR, SEL_DR,
    SEL_IR, TLR};

  // pull-up holds the line high whenever the driver is off
  assign tdoWire = tdoEn ? tdo : 1'b1;

  tapp_port i_dut (.core_clk(core_clk), .reset(reset), .pins(pins),
    .pullDisable(pullDisable), .tdo(tdo), .tdoEn(tdoEn),
    .pullUpEn(pullUpEn), .tapState(tapState), .instr(instr));
  tapp_probe i_probe (.core_clk(core_clk), .tdoWire(tdoWire),
    .pins(pins));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // state and data out both belong to the previous test clock's state
  task automatic step(input logic m, input logic d,
                      output tapp_state_t st, output logic o,
                      output logic e);
    i_probe.rise(m, d);
    st = tapState;
    i_probe.fall(o);
    e = tdoEn;
  endtask

  task automatic nav(input logic [7:0] b, input int n);
    tapp_state_t st;
    logic        o;
    logic        e;
    for (int i = 0; i < n; i++) begin
      step(b[i], 1'b1, st, o, e);
    end
    repeat (2) @(posedge core_clk);
  endtask

  task automatic shift(input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    tapp_state_t st;
    logic        o;
    logic        e;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], st, o, e);
      dout[i] = o;
      chk("tdoEn", 1, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_start();
    reset <= 1'b1;
    i_probe.setTrst(1'b0);
    repeat (12) @(posedge core_clk);
    chk("tdoEn", 0, tdoEn);
    chk("tapState", TLR, tapState);
    chk("instr", IR_IDCODE, instr);
    reset <= 1'b0;
    i_probe.setTrst(1'b1);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic t_walk();
    tapp_state_t st;
    logic        o;
    logic        e;
    for (int k = 0; k < 24; k++) begin
      step(WALK_TMS[k], 1'b1, st, o, e);
      chk("tapState", walkSt[k], st);
      chk("tdoEn", st inside {SHIFT_DR, SHIFT_IR}, e);
    end
  endtask

  task automatic t_scan();
    logic [31:0] v;
    nav(8'h06, 5);
    shift(4, {28'h0, IR_BYPASS}, v);
    chk("irOut", IR_CAPTURE, v);
    nav(8'h01, 2);
    chk("instr", IR_BYPASS, instr);
    nav(8'h01, 3);
    shift(4, 32'hb, v);
    chk("bypassOut", 32'h6, v);
    nav(8'h01, 2);
    i_probe.setTrst(1'b0);
    repeat (8) @(posedge core_clk);
    chk("tapState", TLR, tapState);
    chk("instr", IR_IDCODE, instr);
    i_probe.setTrst(1'b1);
    repeat (8) @(posedge core_clk);
    nav(8'h02, 4);
    shift(32, 32'h0, v);
    chk("idOut", ID_VALUE, v);
  endtask

  task automatic t_sysreset();
    nav(8'h02, 3);
    repeat (6) @(posedge core_clk);
    chk("tdoEn", 1, tdoEn);
    reset <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("tdoEn", 0, tdoEn);
    chk("pullUpEn", PULL_ON, pullUpEn);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("tapState", SHIFT_DR, tapState);
    pullDisable <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("pullUpEn", PULL_OFF, pullUpEn);
    pullDisable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("pullUpEn", PULL_ON, pullUpEn);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    pullDisable = 1'b0;
    @(posedge core_clk);
    t_start();
    t_walk();
    t_scan();
    t_sysreset();
    stop_test();
  end

  // whole run is near 170 test-clock phases, about 20 us; this is ample
  initial begin
    #500us;
    n_mismatch++;
    stop_test();
  end
endmodule // tb_tapp_port
